/* hw/mpo_pkg.sv */
package mpo_pkg;
   localparam int unsigned NCH = 6;
   localparam int unsigned NPAIR = 3;
   localparam int unsigned NFLT = 4;
   localparam int unsigned NSTS = 3;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 7;
   localparam logic [5:0] IDX_OUT = 6'h00;
   localparam logic [5:0] IDX_CNT = 6'h01;
   localparam logic [5:0] IDX_MOD = 6'h02;
   localparam logic [5:0] IDX_VAL0 = 6'h03;
   localparam logic [5:0] IDX_VAL5 = 6'h08;
   localparam logic [5:0] IDX_DT = 6'h09;
   localparam logic [5:0] IDX_MAP1 = 6'h0A;
   localparam logic [5:0] IDX_MAP2 = 6'h0B;
   localparam logic [5:0] IDX_CFG = 6'h0C;
   localparam logic [5:0] IDX_CCR = 6'h0D;
   localparam logic [5:0] IDX_PORT = 6'h0E;
   localparam logic [5:0] IDX_CTL = 6'h0F;
   localparam int unsigned OUT_PAD = 15;
   localparam int unsigned OUT_OVR = 8;
   localparam int unsigned CFG_EDG = 12;
   localparam int unsigned CFG_TOP = 8;
   localparam int unsigned CFG_BOT = 4;
   localparam int unsigned CFG_IND = 1;
   localparam int unsigned CFG_WP = 0;
   localparam int unsigned CCR_HARDWARE_ACCELERATION_ENABLE = 15;
   localparam int unsigned CCR_MSK = 8;
   localparam int unsigned CCR_VLM = 4;
   localparam int unsigned CTL_PRSC = 6;
   localparam int unsigned CTL_LOAD_OKAY = 1;
   localparam int unsigned CTL_EN = 0;
   localparam int unsigned MAP_PINS_LO = 4;
   localparam logic [7:0] DT_RST = 8'hFF;
   localparam logic [15:0] MAP1_RST = 16'hFFFF;
   localparam logic [7:0] MAP2_RST = 8'hFF;
   localparam logic [14:0] MOD_RST = 15'h0001;
   localparam logic [1:0] VLM_ALL6 = 2'h1;
   localparam logic [1:0] VLM_ALL4 = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic aw_v;
      logic [5:0] aw_i;
      logic aw_ok;
      logic w_v;
      logic [15:0] w_d;
      logic [1:0] w_s;
      logic awrdy;
      logic wrdy;
      logic arrdy;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [15:0] rd;
      logic [1:0] rr;
      logic pad_en;
      logic [5:0] ovr_en;
      logic [5:0] sw_out;
      logic [14:0] mod_b;
      logic [14:0] mod_a;
      logic [5:0][15:0] val_b;
      logic [5:0][15:0] val_a;
      logic [7:0] dt;
      logic [15:0] map1;
      logic [7:0] map2;
      logic edge_align_select;
      logic wp;
      logic [2:0] top_side_invert;
      logic [2:0] bottom_side_invert;
      logic [2:0] pair_independent_select;
      logic hardware_acceleration_enable;
      logic [5:0] msk;
      logic [1:0] vlm;
      logic [2:0] pair_swap;
      logic [1:0] prsc_b;
      logic [1:0] prsc_a;
      logic load_okay;
      logic pwmen;
      logic [2:0] pre;
      logic [14:0] cnt;
      logic down;
      logic [2:0][10:0] dtc;
      logic [2:0] rawp;
      logic [5:0] pwm;
      logic [5:0] oe;
   } mpo_state_t;
endpackage

/* hw/mpo_top.sv */
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mpo_top import mpo_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   input wire logic [NFLT-1:0] fault_i,
   input wire logic [NSTS-1:0] status_i,
   output logic [NCH-1:0] pwm_o,
   output logic [NCH-1:0] pwm_oe_o
);
   if (ADDR_W != IDX_MSB + 1) begin : g_chk
      $error("mpo_top: ADDR_W must be 8");
   end

   localparam mpo_state_t RST = '{
      awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1,
      mod_b: MOD_RST, mod_a: MOD_RST,
      dt: DT_RST, map1: MAP1_RST, map2: MAP2_RST,
      default: '0};

   mpo_state_t s;
   mpo_state_t n;
   logic wr_go;
   logic wr_ctl;
   logic reload;
   logic tick;
   logic [2:0] pmax;
   logic [15:0] wd;
   logic [10:0] dtl;
   logic [NCH-1:0] act;
   logic [NCH-1:0] dis;
   logic t;
   logic b;
   logic r;
   logic busy;
   logic sw;

   function automatic logic [15:0] rdreg(mpo_state_t st, logic [5:0] idx, logic [6:0] port);
      logic [15:0] v;
      v = '0;
      case (idx)
         IDX_OUT: v = {st.pad_en, 1'b0, st.ovr_en, 2'b00, st.sw_out};
         IDX_CNT: v = {1'b0, st.cnt};
         IDX_MOD: v = {1'b0, st.mod_b};
         IDX_DT: v = {8'h00, st.dt};
         IDX_MAP1: v = st.map1;
         IDX_MAP2: v = {8'h00, st.map2};
         IDX_CFG: v = {3'h0, st.edge_align_select, 1'b0, st.top_side_invert, 1'b0, st.bottom_side_invert, st.pair_independent_select, st.wp};
         IDX_CCR: v = {st.hardware_acceleration_enable, 1'b0, st.msk, 2'b00, st.vlm, 1'b0, st.pair_swap};
         IDX_PORT: v = {9'h000, port};
         IDX_CTL: v = {8'h00, st.prsc_b, 4'h0, st.load_okay, st.pwmen};
         default: begin
            if (idx >= IDX_VAL0 && idx <= IDX_VAL5) begin
               v = st.val_b[3'(idx - IDX_VAL0)];
            end
         end
      endcase
      return v;
   endfunction

   function automatic logic [15:0] mrg(logic [15:0] old, logic [15:0] d, logic [1:0] stb);
      logic [15:0] v;
      v = old;
      for (int k = 0; k < 2; k++) begin
         if (stb[k]) begin
            v[8*k+:8] = d[8*k+:8];
         end
      end
      return v;
   endfunction

   always_comb begin
      n = s;
      wr_go = s.aw_v & s.w_v & ~s.bv;
      wr_ctl = wr_go & (s.aw_i == IDX_CTL);
      reload = 1'b0;
      pmax = 3'((4'h1 << s.prsc_a) - 4'h1);
      tick = (s.pre == pmax);
      wd = mrg(rdreg(s, s.aw_i, {status_i, fault_i}), s.w_d, s.w_s);
      dtl = '0;
      act = '0;
      dis = '0;
      t = 1'b0;
      b = 1'b0;
      r = 1'b0;
      busy = 1'b0;
      sw = 1'b0;

      // counter and reload; prescaler divides the bus clock by 1, 2, 4 or 8
      if (!s.pwmen) begin
         n.pre = '0;
         n.cnt = '0;
         n.down = 1'b0;
         reload = 1'b1;
      end else begin
         n.pre = tick ? 3'h0 : 3'(s.pre + 3'h1);
         if (tick) begin
            if (s.edge_align_select) begin
               n.down = 1'b0;
               if (s.cnt >= 15'(s.mod_a - 15'h1)) begin
                  n.cnt = '0;
                  reload = 1'b1;
               end else begin
                  n.cnt = 15'(s.cnt + 15'h1);
               end
            end else if (!s.down) begin
               if (s.cnt >= 15'(s.mod_a - 15'h1)) begin
                  n.down = 1'b1;
               end else begin
                  n.cnt = 15'(s.cnt + 15'h1);
               end
            end else if (s.cnt == '0) begin
               n.down = 1'b0;
               reload = 1'b1;
            end else begin
               n.cnt = 15'(s.cnt - 15'h1);
            end
         end
      end
      if (reload && s.load_okay) begin
         n.prsc_a = s.prsc_b;
         n.mod_a = s.mod_b;
         n.val_a = s.val_b;
         n.load_okay = 1'b0;
      end

      // register writes come after the reload so a software set of load okay wins
      if (wr_go) begin
         n.aw_v = 1'b0;
         n.w_v = 1'b0;
         n.bv = 1'b1;
         n.br = s.aw_ok ? RESP_OKAY : RESP_SLVERR;
         if (s.aw_ok) begin
            case (s.aw_i)
               IDX_OUT: begin
                  n.pad_en = wd[OUT_PAD];
                  n.ovr_en = wd[OUT_OVR+:NCH];
                  n.sw_out = wd[NCH-1:0];
               end
               IDX_MOD: n.mod_b = wd[14:0];
               IDX_DT: if (!s.wp) n.dt = wd[7:0];
               IDX_MAP1: if (!s.wp) n.map1 = wd;
               IDX_MAP2: if (!s.wp) n.map2 = wd[7:0];
               IDX_CFG: begin
                  if (!s.wp) begin
                     n.edge_align_select = wd[CFG_EDG];
                     n.top_side_invert = wd[CFG_TOP+:NPAIR];
                     n.bottom_side_invert = wd[CFG_BOT+:NPAIR];
                     n.pair_independent_select = wd[CFG_IND+:NPAIR];
                     n.wp = wd[CFG_WP];
                  end
               end
               IDX_CCR: begin
                  if (!s.wp) begin
                     n.hardware_acceleration_enable = wd[CCR_HARDWARE_ACCELERATION_ENABLE];
                     n.msk = wd[CCR_MSK+:NCH];
                     if (s.hardware_acceleration_enable) begin
                        n.vlm = wd[CCR_VLM+:2];
                        n.pair_swap = wd[NPAIR-1:0];
                     end
                  end
               end
               IDX_CTL: begin
                  n.prsc_b = wd[CTL_PRSC+:2];
                  n.load_okay = wd[CTL_LOAD_OKAY];
                  n.pwmen = wd[CTL_EN];
               end
               default: begin
                  for (int i = 0; i < NCH; i++) begin
                     if (s.aw_i == 6'(IDX_VAL0 + 6'(i))) begin
                        n.val_b[i] = wd;
                     end
                     if (s.aw_i == IDX_VAL0) begin
                        if (s.vlm == VLM_ALL6 || (s.vlm == VLM_ALL4 && i < 4)) begin
                           n.val_b[i] = wd;
                        end
                     end
                  end
               end
            endcase
         end
      end
      if (s.bv && bready_i) begin
         n.bv = 1'b0;
      end
      if (awvalid_i && s.awrdy) begin
         n.aw_v = 1'b1;
         n.aw_i = awaddr_i[IDX_MSB:IDX_LSB];
         n.aw_ok = (awaddr_i[IDX_MSB:IDX_LSB] <= IDX_CTL);
      end
      if (wvalid_i && s.wrdy) begin
         n.w_v = 1'b1;
         n.w_d = wdata_i[15:0];
         n.w_s = wstrb_i[1:0];
      end
      n.awrdy = ~n.aw_v & ~n.bv;
      n.wrdy = ~n.w_v & ~n.bv;
      if (s.rv && rready_i) begin
         n.rv = 1'b0;
      end
      if (arvalid_i && s.arrdy) begin
         n.rv = 1'b1;
         n.rd = rdreg(s, araddr_i[IDX_MSB:IDX_LSB], {status_i, fault_i});
         n.rr = (araddr_i[IDX_MSB:IDX_LSB] <= IDX_CTL) ? RESP_OKAY : RESP_SLVERR;
      end
      n.arrdy = ~n.rv;

      // waveform compare in signed 18 bits covers negative widths and widths past the modulus
      for (int i = 0; i < NCH; i++) begin
         if (s.edge_align_select) begin
            act[i] = $signed({3'b000, s.cnt}) < $signed({{2{s.val_a[i][15]}}, s.val_a[i]});
         end else begin
            act[i] = ($signed({3'b000, s.cnt}) + $signed({{2{s.val_a[i][15]}}, s.val_a[i]}))
                     >= $signed({3'b000, s.mod_a});
         end
         act[i] = act[i] & ~s.msk[i] & s.pwmen;
         if (i < MAP_PINS_LO) begin
            dis[i] = |(fault_i & s.map1[NFLT*i+:NFLT]);
         end else begin
            dis[i] = |(fault_i & s.map2[NFLT*(i-MAP_PINS_LO)+:NFLT]);
         end
      end

      // dead time counts bus clocks: P*count-1, or the count when P is one
      if (s.dt == '0) begin
         dtl = '0;
      end else if (s.prsc_a == '0) begin
         dtl = {3'b000, s.dt};
      end else begin
         dtl = 11'(({3'b000, s.dt} << s.prsc_a) - 11'h001);
      end

      for (int p = 0; p < NPAIR; p++) begin
         if (s.pair_independent_select[p]) begin
            t = act[2*p];
            b = act[2*p+1];
            n.dtc[p] = '0;
            n.rawp[p] = act[2*p];
         end else begin
            r = act[2*p];
            n.rawp[p] = r;
            busy = (s.dtc[p] != '0) || ((r != s.rawp[p]) && (dtl != '0));
            if (r != s.rawp[p]) begin
               // the edge cycle is the first dead clock, so count-1 remain; a zero count leaves no gap
               n.dtc[p] = (dtl == '0) ? '0 : 11'(dtl - 11'h001);
            end else if (s.dtc[p] != '0) begin
               n.dtc[p] = 11'(s.dtc[p] - 11'h001);
            end
            t = r & ~busy;
            b = ~r & ~busy & s.pwmen;
         end
         if (s.pair_swap[p]) begin
            sw = t;
            t = b;
            b = sw;
         end
         if (s.ovr_en[2*p]) begin
            t = s.sw_out[2*p];
         end
         if (s.ovr_en[2*p+1]) begin
            b = s.pair_independent_select[p] ? s.sw_out[2*p+1] : (s.sw_out[2*p+1] & ~t);
         end
         n.pwm[2*p] = (t & ~dis[2*p]) ^ s.top_side_invert[p];
         n.pwm[2*p+1] = (b & ~dis[2*p+1]) ^ s.bottom_side_invert[p];
      end
      n.oe = {NCH{s.pad_en}};
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s <= RST;
      end else if (ce_i) begin
         s <= n;
      end
   end

   assign awready_o = s.awrdy;
   assign wready_o = s.wrdy;
   assign bvalid_o = s.bv;
   assign bresp_o = s.br;
   assign arready_o = s.arrdy;
   assign rvalid_o = s.rv;
   assign rresp_o = s.rr;
   assign rdata_o = {16'h0000, s.rd};
   assign pwm_o = s.pwm;
   assign pwm_oe_o = s.oe;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   pad_oe_follow_a: assert property (
      ce_i |=> pwm_oe_o == {NCH{$past(s.pad_en)}})
      else $error("pad enable does not reach output enable");
   reload_take_a: assert property (
      ce_i && reload && s.load_okay && !wr_ctl |=> !s.load_okay && s.mod_a == $past(s.mod_b)
         && s.val_a == $past(s.val_b))
      else $error("reload did not apply buffers or clear load okay");
   wp_lock_a: assert property (
      s.wp |=> s.wp && $stable(s.dt) && $stable(s.map1) && $stable(s.map2) && $stable(s.edge_align_select))
      else $error("protected register changed while locked");
   port_read_a: assert property (
      ce_i && arvalid_i && arready_o && araddr_i[IDX_MSB:IDX_LSB] == IDX_PORT
         |=> rvalid_o && rdata_o[6:0] == $past({status_i, fault_i}) && rdata_o[31:7] == '0)
      else $error("port register read wrong");
   mask_zero_a: assert property (
      ce_i && s.msk[2] && s.pair_independent_select[1] && !s.ovr_en[2] && !s.pair_swap[1]
         |=> pwm_o[2] == $past(s.top_side_invert[1]))
      else $error("masked channel not inactive");
   fault_off_a: assert property (
      ce_i && fault_i[0] && s.map1[0] |=> pwm_o[0] == $past(s.top_side_invert[0]))
      else $error("fault did not disable pin");
   override_pin_a: assert property (
      ce_i && s.ovr_en[0] && !(|(fault_i & s.map1[NFLT-1:0]))
         |=> pwm_o[0] == ($past(s.sw_out[0]) ^ $past(s.top_side_invert[0])))
      else $error("override bit not on pin");
   low_width_a: assert property (
      ce_i && s.edge_align_select && $signed(s.val_a[3]) <= 0 && s.pair_independent_select[1] && !s.ovr_en[3] && !s.pair_swap[1]
         |=> pwm_o[3] == $past(s.bottom_side_invert[1]))
      else $error("non-positive width drove pin active");
   load_okay_set_wins_a: assert property (
      ce_i && wr_ctl && wd[CTL_LOAD_OKAY] |=> s.load_okay)
      else $error("software set of load okay lost");
   dead_gap_a: assert property (
      ce_i && !s.pair_independent_select[2] && s.dtc[2] != '0 && !s.pair_swap[2] && s.ovr_en[5:4] == 2'b00
         |=> pwm_o[4] == $past(s.top_side_invert[2]) && pwm_o[5] == $past(s.bottom_side_invert[2]))
      else $error("pair not held off during dead time");
   // the bound leaves out a modulus of zero, for which the counter runs up to 7FFF
   cnt_bound_a: assert property (
      ce_i && s.pwmen && s.mod_a != '0 |-> s.cnt < s.mod_a)
      else $error("counter ran past the modulus");
   cnt_read_a: assert property (
      ce_i && arvalid_i && arready_o && araddr_i[IDX_MSB:IDX_LSB] == IDX_CNT
         |=> rvalid_o && rdata_o[15:0] == {1'b0, $past(s.cnt)})
      else $error("counter register read wrong");
   ccr_lock_a: assert property (
      s.wp |=> $stable(s.hardware_acceleration_enable) && $stable(s.msk) && $stable(s.vlm) && $stable(s.pair_swap))
      else $error("channel control changed while locked");
   map_hi_a: assert property (
      ce_i && |(fault_i & s.map2[2*NFLT-1:NFLT]) |=> pwm_o[5] == $past(s.bottom_side_invert[2]))
      else $error("second map did not disable pin five");
   ovr_comp_a: assert property (
      ce_i && !s.pair_independent_select[0] && s.ovr_en[1:0] == 2'b11 && !(|(fault_i & s.map1[2*NFLT-1:NFLT]))
         |=> pwm_o[1] == (($past(s.sw_out[1]) & ~$past(s.sw_out[0])) ^ $past(s.bottom_side_invert[0])))
      else $error("complementary override of odd pin wrong");

   reload_c: cover property (ce_i && reload && s.load_okay && s.pwmen);
   lock_c: cover property (ce_i && wr_go && s.aw_i == IDX_CFG && s.wp);
   dead_c: cover property (ce_i && s.pwmen && !s.pair_independent_select[0] && s.dtc[0] != '0);
   center_c: cover property (ce_i && s.pwmen && !s.edge_align_select && s.down);
   swap_c: cover property (ce_i && s.pwmen && |s.pair_swap);
endmodule
`default_nettype wire

/* sim/mpo_gate_drv.sv */
`timescale 1ns/1ps
`default_nettype none
module mpo_gate_drv import mpo_pkg::*; (
   input wire logic ref_clk_i,
   input wire logic [NCH-1:0] pwm_i,
   input wire logic [NCH-1:0] oe_i,
   input wire logic [NFLT-1:0] fault_set_i,
   input wire logic [NSTS-1:0] status_set_i,
   output logic [NFLT-1:0] fault_o,
   output logic [NSTS-1:0] status_o,
   output logic [NCH-1:0] gate_o
);
   logic [NCH-1:0] float_q = 6'h2A;
   // a released pad is not a clean level: the driver input wanders every cycle
   always @(posedge ref_clk_i) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < NCH; i++) gate_o[i] = oe_i[i] ? pwm_i[i] : float_q[i];
   end
   initial begin
      fault_o = '0;
      status_o = '0;
   end
   // comparator outputs of the power stage move just after an edge
   always @(posedge ref_clk_i) begin
      fault_o <= fault_set_i;
      status_o <= status_set_i;
   end
endmodule
`default_nettype wire

/* sim/motor_pwm_output_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_pwm_output_config_test import mpo_pkg::*; ;
   logic ref_clk_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic ce = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [NFLT-1:0] flt_set = '0, fault;
   logic [NSTS-1:0] sts_set = '0, status;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [NCH-1:0] pwm, oe, gate;
   int error_cnt = 0, total_checks = 0;
   logic [31:0] seed = 32'h9B21D17E;
   logic [15:0] mdl [16];
   logic [15:0] rdv;
   int hi [NCH];
   localparam logic [15:0] WV [NCH] = '{16'h0003, 16'h0000, 16'h000C, 16'hFFFF, 16'h0005, 16'h0007};

   always #4 ref_clk_i = ~ref_clk_i;

   mpo_top dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
      .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hF),
      .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
      .rvalid_o(rvalid), .rready_i(rready), .fault_i(fault), .status_i(status), .pwm_o(pwm), .pwm_oe_o(oe));
   mpo_gate_drv drv_u (.ref_clk_i(ref_clk_i), .pwm_i(pwm), .oe_i(oe), .fault_set_i(flt_set),
      .status_set_i(sts_set), .fault_o(fault), .status_o(status), .gate_o(gate));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // ideal high time of one period, modulus 12
   function automatic int duty(input logic [15:0] w, input int k);
      return ($signed(w) <= 0 ? 0 : $signed(w) >= 12 ? 12 : int'($signed(w))) * k;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [5:0] ix, input logic [15:0] v, input logic [1:0] er = RESP_OKAY);
      bit aw, w;
      aw = 1;
      w = 1;
      awaddr <= {ix, 2'h0};
      wdata <= {16'h0000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (aw || w || bvalid !== 1'h1) begin
         @(posedge ref_clk_i);
         if (aw && awready === 1'h1) begin
            awvalid <= 1'h0;
            aw = 0;
         end
         if (w && wready === 1'h1) begin
            wvalid <= 1'h0;
            w = 0;
         end
      end
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [5:0] ix, input logic [1:0] er = RESP_OKAY);
      bit a;
      a = 1;
      araddr <= {ix, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (a || rvalid !== 1'h1) begin
         @(posedge ref_clk_i);
         if (a && arready === 1'h1) begin
            arvalid <= 1'h0;
            a = 0;
         end
      end
      rdv = rdata[15:0];
      chk("rresp", {30'h0, rresp}, {30'h0, er});
      chk("rdata_top", {16'h0, rdata[31:16]}, 32'h0);
   endtask

   task automatic mdl_init();
      foreach (mdl[i]) mdl[i] = 16'h0000;
      mdl[IDX_MOD] = 16'h0001;
      mdl[IDX_DT] = 16'h00FF;
      mdl[IDX_MAP1] = 16'hFFFF;
      mdl[IDX_MAP2] = 16'h00FF;
   endtask

   // write through the bus and keep the register mirror in step
   task automatic wm(input logic [5:0] ix, input logic [15:0] v);
      bit wp;
      wp = mdl[IDX_CFG][0];
      wr(ix, v);
      if (ix == IDX_OUT) mdl[ix] = v & 16'hBF3F;
      if (ix == IDX_MOD) mdl[ix] = v & 16'h7FFF;
      if (ix >= IDX_VAL0 && ix <= IDX_VAL5) mdl[ix] = v;
      if (ix == IDX_VAL0) begin
         for (int i = 1; i < NCH; i++) begin
            if (mdl[IDX_CCR][5:4] == 2'h1 || (mdl[IDX_CCR][5:4] == 2'h2 && i < 4)) mdl[IDX_VAL0 + i] = v;
         end
      end
      if (!wp) begin
         if (ix == IDX_DT || ix == IDX_MAP2) mdl[ix] = v & 16'h00FF;
         if (ix == IDX_MAP1) mdl[ix] = v;
         if (ix == IDX_CFG) mdl[ix] = v & 16'h177F;
         if (ix == IDX_CCR) mdl[ix] = (v & 16'hBF00) | (mdl[ix][15] ? v & 16'h0037 : mdl[ix] & 16'h0037);
      end
      if (ix == IDX_CTL) mdl[ix] = v & 16'h00C3;
   endtask

   task automatic sweep();
      for (int i = 0; i < 14; i++) begin
         if (i != 1) begin
            rd(i[5:0]);
            chk($sformatf("reg%0d", i), {16'h0, rdv}, {16'h0, mdl[i]});
         end
      end
   endtask

   task automatic measure(input int win);
      foreach (hi[i]) hi[i] = 0;
      repeat (win) begin
         @(posedge ref_clk_i);
         foreach (hi[i]) hi[i] += (gate[i] === 1'h1);
      end
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      wrap_up();
   end

   initial begin
      int k, h, e [NCH];
      logic [15:0] v;
      logic [5:0] ix;
      mdl_init();
      repeat (10) @(posedge ref_clk_i);
      reset_n_i <= 1'h1;
      @(posedge ref_clk_i);
      chk("pad_oe", {26'h0, oe}, 32'h0);
      sweep();
      rd(6'h10, RESP_SLVERR);
      chk("unmapped", {16'h0, rdv}, 32'h0);
      wr(6'h11, 16'h1234, RESP_SLVERR);
      repeat (3) begin
         flt_set <= 4'(rnd());
         sts_set <= 3'(rnd());
         wr(IDX_PORT, 16'hFFFF);
         rd(IDX_PORT);
         chk("port", {16'h0, rdv}, {25'h0, sts_set, flt_set});
      end
      flt_set <= '0;
      repeat (20) begin
         ix = IDX_MOD + 6'(rnd() % 7);
         v = 16'(rnd());
         if (ix == IDX_MOD && v[14:0] == 15'h0) v = 16'h0001;
         wm(ix, v);
      end
      sweep();
      wm(IDX_CCR, 16'h0015);
      for (int m = 0; m < 4; m++) begin
         wm(IDX_CCR, 16'h8000 | 16'(m << 4));
         wm(IDX_VAL0, 16'(rnd()));
         sweep();
      end
      wm(IDX_CCR, 16'h8000);
      wm(IDX_OUT, 16'h8000);
      wm(IDX_DT, 16'h0002);
      wm(IDX_MOD, 16'h000C);
      for (int i = 0; i < NCH; i++) wm(IDX_VAL0 + 6'(i), WV[i]);
      chk("pad_oe", {26'h0, oe}, 32'h3F);
      for (int p = 0; p < 2; p++) begin
         k = p + 1;
         wm(IDX_CTL, 16'h0000);
         wm(IDX_CFG, p ? 16'h0006 : 16'h1006);
         wm(IDX_CCR, p ? 16'h8401 : 16'h8000);
         wm(IDX_CTL, 16'h0003);
         repeat (40) @(posedge ref_clk_i);
         measure(12 * k);
         for (int i = 0; i < 4; i++) e[i] = mdl[IDX_CCR][8 + i] ? 0 : duty(mdl[IDX_VAL0 + i], k);
         if (mdl[IDX_CCR][0]) begin
            h = e[0];
            e[0] = e[1];
            e[1] = h;
         end
         h = duty(mdl[IDX_VAL0 + 4], k);
         e[4] = h - 2;
         e[5] = 12 * k - h - 2;
         for (int i = 0; i < NCH; i++) chk("high", hi[i], e[i]);
         rd(IDX_CTL);
         chk("load_okay", {16'h0, rdv}, 32'h1);
         rd(IDX_CNT);
         chk("cnt", {31'h0, rdv < 16'h000C}, 32'h1);
      end
      // with the clock enable low the running generator must freeze its pins
      ce <= 1'h0;
      repeat (2) @(posedge ref_clk_i);
      v = {10'h000, pwm};
      repeat (8) @(posedge ref_clk_i);
      chk("freeze", {26'h0, pwm}, {16'h0, v});
      ce <= 1'h1;
      flt_set <= 4'h1;
      repeat (4) @(posedge ref_clk_i);
      measure(24);
      for (int i = 0; i < NCH; i++) chk("fault", hi[i], 0);
      flt_set <= 4'h0;
      wm(IDX_CTL, 16'h0000);
      wm(IDX_CFG, 16'h0210);
      wm(IDX_OUT, 16'hBF0A);
      repeat (3) @(posedge ref_clk_i);
      chk("ovr_comp", {26'h0, pwm}, 32'h0C);
      wm(IDX_CFG, 16'h021E);
      wm(IDX_OUT, 16'hBF25);
      repeat (3) @(posedge ref_clk_i);
      chk("ovr_ind", {26'h0, pwm}, 32'h23);
      wm(IDX_OUT, 16'h8000);
      repeat (3) @(posedge ref_clk_i);
      chk("ovr_off", {26'h0, pwm}, 32'h06);
      wm(IDX_CFG, 16'h1001);
      for (int i = 9; i < 14; i++) wm(6'(i), 16'h0000);
      sweep();
      reset_n_i <= 1'h0;
      repeat (10) @(posedge ref_clk_i);
      reset_n_i <= 1'h1;
      @(posedge ref_clk_i);
      mdl_init();
      chk("pad_oe", {26'h0, oe}, 32'h0);
      wm(IDX_DT, 16'h0012);
      sweep();
      wrap_up();
   end
endmodule
`default_nettype wire
